// [wpm_pkg.sv]
// Package for the wake pin monitor: modes, filter timing, reset values.
// Assumes a 200 MHz system clock and a mode controller that owns the mode code.
// Operation
// - Both rising and falling wake input transitions count as wake events.
// - A new level is accepted only after persisting for the filter time.
// - Wake function is switched on and off by the enable bit, except the Fail-Safe Restart request.
// - Below undervoltage off level the input is ignored entirely.
// - Filtered wake level is readable in Normal, Stop and programming modes.
// - Enabled and in Sleep, any qualified transition wakes the chip.
// - In Fail-Safe any qualified transition requests Restart.
// - Enabled in active modes, each change sets its edge flag and interrupt.
// - Rising and falling interrupts are masked independently.
// - Normal-to-Sleep change is blocked while either edge flag is set.
// - A flag set at or before the Sleep request wakes the chip again.
// - In Stop a wake drives the interrupt and sets a readable flag.
package wpm_pkg;

  // --------------------------------------------------------------------
  // Mode codes presented by the mode controller
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    WPM_MODE_NORMAL = 3'h0,
    WPM_MODE_STOP = 3'h1,
    WPM_MODE_SLEEP = 3'h2,
    WPM_MODE_RESTART = 3'h3,
    WPM_MODE_FAILSAFE = 3'h4,
    WPM_MODE_FLASH = 3'h5,
    WPM_MODE_INIT = 3'h6
  } wpm_mode_t;

  // --------------------------------------------------------------------
  // Filter timing
  // --------------------------------------------------------------------
  localparam int WPM_CLK_MHZ = 200;
  localparam int WPM_FILT_MIN_US = 10;
  localparam int WPM_FILT_MAX_US = 25;
  // Aim in the middle of the window to tolerate oscillator drift
  localparam int WPM_FILT_CYC = (WPM_FILT_MIN_US + WPM_FILT_MAX_US) * WPM_CLK_MHZ / 2;
  localparam int WPM_CNT_W = 13;

  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic WPM_LEVEL_RST = 1'b0;
  localparam logic WPM_FLAG_RST = 1'b0;

endpackage : wpm_pkg

// [wpm_filt_if.sv]
// Interface carrying the filtered wake level and qualified edge pulses.
// Assumes one clock domain shared by filter and monitor.
`timescale 1ns/10ps
interface wpm_filt_if;
  logic level;
  logic rise;
  logic fall;
  modport filt (output level, output rise, output fall);
  modport mon (input level, input rise, input fall);
endinterface : wpm_filt_if

// [wpm_filter.sv]
// Wake input synchroniser and persistence filter.
// Assumes the raw pin is asynchronous to sys_clk_in.
`timescale 1ns/10ps
module wpm_filter (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [wpm_pkg::WPM_CNT_W-1:0] filt_cyc_in,
  // Raw pin and result
  input wire logic pin_in,
  input wire logic hold_in,
  wpm_filt_if.filt res
);

  logic sync1, sync2, next_sync1, next_sync2;
  logic stable, next_stable;
  logic [wpm_pkg::WPM_CNT_W-1:0] cnt, next_cnt;
  logic rise, fall, next_rise, next_fall;

  // --------------------------------------------------------------------
  // Next-state: sync, count persistence, qualify edge
  // --------------------------------------------------------------------
  always_comb begin
    next_sync1 = pin_in;
    next_sync2 = sync1;
    next_stable = stable;
    next_cnt = '0;
    next_rise = 1'b0;
    next_fall = 1'b0;
    // Pin is high impedance when powered down: hold and forget
    if (hold_in) begin
      next_cnt = '0;
    end else if (sync2 != stable) begin
      // Counter restarts whenever the level returns to stable
      if (cnt >= filt_cyc_in - 1'b1) begin
        next_stable = sync2;
        next_rise = sync2;
        next_fall = ~sync2;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      stable <= wpm_pkg::WPM_LEVEL_RST;
      cnt <= '0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      stable <= next_stable;
      cnt <= next_cnt;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

  assign res.level = stable;
  assign res.rise = rise;
  assign res.fall = fall;

endmodule // wpm_filter

// [wpm_monitor.sv]
// Wake pin monitor top: filter, edge flags, mode-dependent wake requests.
// Assumes the mode controller supplies the mode and acts on the requests.
`timescale 1ns/10ps
module wpm_monitor #(
  parameter logic [wpm_pkg::WPM_CNT_W-1:0] FILT_CYC = wpm_pkg::WPM_CNT_W'(wpm_pkg::WPM_FILT_CYC)
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Pin and power
  input wire logic external_wake_input_in,
  input wire logic undervoltage_off_in,
  // Mode controller
  input wire logic [2:0] mode_in,
  input wire logic sleep_req_in,
  output logic sleep_grant_out,
  output logic wake_sleep_out,
  output logic restart_req_out,
  // Control bits
  input wire logic wake_pin_enable_bit_in,
  input wire logic mask_rise_in,
  input wire logic mask_fall_in,
  input wire logic clear_flag_a_in,
  input wire logic clear_flag_b_in,
  // Status
  output logic wake_pin_level_bit_out,
  output logic wake_edge_flag_a_out,
  output logic wake_edge_flag_b_out,
  output logic irq_out
);

  wpm_filt_if fif ();
  wpm_pkg::wpm_mode_t mode;
  logic active, en;
  logic flag_a, flag_b, next_flag_a, next_flag_b;
  logic level, next_level;
  logic wake_s, next_wake_s, rst_req, next_rst_req;

  assign mode = wpm_pkg::wpm_mode_t'(mode_in);
  assign en = wake_pin_enable_bit_in & ~undervoltage_off_in;
  assign active = (mode == wpm_pkg::WPM_MODE_NORMAL) || (mode == wpm_pkg::WPM_MODE_STOP) ||
                  (mode == wpm_pkg::WPM_MODE_FLASH);

  // --------------------------------------------------------------------
  // Filter
  // --------------------------------------------------------------------
  wpm_filter u_filter (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .filt_cyc_in(FILT_CYC),
    .pin_in(external_wake_input_in),
    .hold_in(undervoltage_off_in),
    .res(fif.filt)
  );

  // --------------------------------------------------------------------
  // Flags, level and wake requests
  // --------------------------------------------------------------------
  always_comb begin
    next_flag_a = flag_a;
    next_flag_b = flag_b;
    // Clear first so a same-cycle edge wins
    if (clear_flag_a_in) next_flag_a = 1'b0;
    if (clear_flag_b_in) next_flag_b = 1'b0;
    if (en && active && fif.rise) next_flag_a = 1'b1;
    if (en && active && fif.fall) next_flag_b = 1'b1;
    // Level only refreshed in modes where it is readable
    next_level = active ? fif.level : level;
    next_wake_s = 1'b0;
    next_rst_req = 1'b0;
    if (!undervoltage_off_in && (fif.rise || fif.fall)) begin
      if (mode == wpm_pkg::WPM_MODE_SLEEP && en) next_wake_s = 1'b1;
      if (mode == wpm_pkg::WPM_MODE_FAILSAFE) next_rst_req = 1'b1;
    end
    // Pending flag in Sleep means the wake was not lost
    if (mode == wpm_pkg::WPM_MODE_SLEEP && (flag_a || flag_b)) next_wake_s = 1'b1;
  end

  // Register stage
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      flag_a <= wpm_pkg::WPM_FLAG_RST;
      flag_b <= wpm_pkg::WPM_FLAG_RST;
      level <= wpm_pkg::WPM_LEVEL_RST;
      wake_s <= 1'b0;
      rst_req <= 1'b0;
    end else begin
      flag_a <= next_flag_a;
      flag_b <= next_flag_b;
      level <= next_level;
      wake_s <= next_wake_s;
      rst_req <= next_rst_req;
    end
  end

  // Sleep refused while flags pending; controller should clear first
  assign sleep_grant_out = sleep_req_in && (mode == wpm_pkg::WPM_MODE_NORMAL) &&
                           !flag_a && !flag_b;
  assign wake_sleep_out = wake_s;
  assign restart_req_out = rst_req;
  assign wake_pin_level_bit_out = level;
  assign wake_edge_flag_a_out = flag_a;
  assign wake_edge_flag_b_out = flag_b;
  // Separate masks per direction
  assign irq_out = (flag_a & ~mask_rise_in) | (flag_b & ~mask_fall_in);

endmodule // wpm_monitor

// [wpm_properties.sv]
// Port checker for the wake pin monitor.
// Assumes a bind into wpm_monitor; one clock, sync reset.
`timescale 1ns/10ps
module wpm_chk #(
  parameter logic [wpm_pkg::WPM_CNT_W-1:0] FILT_CYC = 4
) (
  // Inputs
  input wire logic sys_clk_in, rst_b_in, external_wake_input_in, undervoltage_off_in,
  input wire logic [2:0] mode_in,
  input wire logic wake_pin_enable_bit_in, mask_rise_in, mask_fall_in,
  input wire logic clear_flag_a_in, clear_flag_b_in,
  // Outputs
  input wire logic sleep_grant_out, wake_sleep_out, restart_req_out, irq_out,
  input wire logic wake_edge_flag_a_out, wake_edge_flag_b_out
);
  logic [7:0] hi_cnt;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // High run length, saturating so long levels stay legal
  always_ff @(posedge sys_clk_in) begin
    hi_cnt <= !external_wake_input_in ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
  end
  a_grant_no_flags: assert property (
    sleep_grant_out |-> !wake_edge_flag_a_out && !wake_edge_flag_b_out) else $error("grant");
  a_irq_mask_map: assert property (
    irq_out == (wake_edge_flag_a_out && !mask_rise_in || wake_edge_flag_b_out && !mask_fall_in))
    else $error("irq");
  a_flag_a_holds: assert property (
    wake_edge_flag_a_out && !clear_flag_a_in |=> wake_edge_flag_a_out) else $error("flag a");
  a_flag_b_holds: assert property (
    wake_edge_flag_b_out && !clear_flag_b_in |=> wake_edge_flag_b_out) else $error("flag b");
  a_uv_no_event: assert property (
    undervoltage_off_in [*4] |-> !$rose(wake_edge_flag_a_out | wake_edge_flag_b_out))
    else $error("uv event");
  a_flag_mode_ok: assert property (
    $rose(wake_edge_flag_a_out | wake_edge_flag_b_out) |-> $past(wake_pin_enable_bit_in)
    && $past(mode_in) inside {3'h0, 3'h1, 3'h5}) else $error("flag mode");
  a_restart_pulse: assert property (
    restart_req_out |-> $past(mode_in) == 3'h4 ##1 !restart_req_out) else $error("restart");
  a_rise_filtered: assert property (
    $rose(wake_edge_flag_a_out) |-> $past(hi_cnt, 3) >= FILT_CYC - 1) else $error("filter");
  c_grant: cover property (sleep_grant_out);
  c_restart: cover property (restart_req_out);
  c_wake: cover property (wake_sleep_out && mode_in == 3'h2);
endmodule // wpm_chk
bind wpm_monitor wpm_chk #(.FILT_CYC(FILT_CYC)) u_chk (.*);

// [wpm_switch.sv]
// Wake switch model on the raw pin.
// Assumes hold is called just after a rising edge.
`timescale 1ns/10ps
module wpm_switch (
  // Clock and pin
  input wire logic sys_clk_in,
  output logic pin_out
);
  initial pin_out = 1'b0;
  // Short holds mimic contact bounce
  task automatic hold(input logic lvl, input int cyc);
    pin_out <= lvl;
    repeat (cyc) @(posedge sys_clk_in);
  endtask
endmodule // wpm_switch

// [tb.sv]
// Self-checking bench of the wake pin monitor.
// Assumes FILT_CYC 4, so a held level qualifies in six cycles and sets its flag in seven.
`timescale 1ns/10ps
module tb;
  localparam logic [wpm_pkg::WPM_CNT_W-1:0] FC = 4;
  logic sys_clk_in = 1'b0, rst_b_in = 1'b0, undervoltage_off_in = 1'b0, sleep_req_in = 1'b0;
  logic wake_pin_enable_bit_in = 1'b1, mask_rise_in = 1'b0, mask_fall_in = 1'b0;
  logic clear_flag_a_in = 1'b0, clear_flag_b_in = 1'b0;
  logic [2:0] mode_in = 3'h0;
  logic external_wake_input_in, sleep_grant_out, wake_sleep_out, restart_req_out;
  logic wake_pin_level_bit_out, wake_edge_flag_a_out, wake_edge_flag_b_out, irq_out;
  integer seed = 43;
  int n_mismatch = 0, checks = 0, m_lvl = 0, m_fa = 0, m_fb = 0;
  int ws_cnt = 0, rs_cnt = 0;
  always #2.5 sys_clk_in = ~sys_clk_in;
  wpm_monitor #(.FILT_CYC(FC)) DUT (.*);
  wpm_switch sw (.sys_clk_in(sys_clk_in), .pin_out(external_wake_input_in));
  // Count pulses mid-cycle where settled; one writer per counter avoids races
  always @(negedge sys_clk_in) begin
    if (wake_sleep_out === 1'b1) ws_cnt++;
    if (restart_req_out === 1'b1) rs_cnt++;
  end
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hold the pin, step the model, compare; modes read after they land
  task automatic drv(input logic v, input int len);
    logic q;
    int ws0;
    int rs0;
    q = len > FC + 4 && v !== m_lvl[0];
    ws0 = ws_cnt;
    rs0 = rs_cnt;
    sw.hold(v, len);
    q = q && !undervoltage_off_in;
    if (q) m_lvl = v;
    if (q && wake_pin_enable_bit_in && mode_in inside {3'h0, 3'h1, 3'h5}) begin
      m_fa = m_fa | v;
      m_fb = m_fb | !v;
    end
    cmp(ws_cnt != ws0, mode_in == 3'h2 && (q && wake_pin_enable_bit_in || m_fa + m_fb > 0));
    cmp(rs_cnt != rs0, q && mode_in == 3'h4);
    if (mode_in inside {3'h0, 3'h1, 3'h5}) cmp(wake_pin_level_bit_out, m_lvl);
    cmp(wake_edge_flag_a_out, m_fa);
    cmp(wake_edge_flag_b_out, m_fb);
    cmp(irq_out, m_fa && !mask_rise_in || m_fb && !mask_fall_in);
    cmp(sleep_grant_out, sleep_req_in && mode_in == 3'h0 && m_fa + m_fb == 0);
  endtask
  // Controller clears both flags
  task automatic clr;
    clear_flag_a_in <= 1'b1;
    clear_flag_b_in <= 1'b1;
    @(posedge sys_clk_in);
    clear_flag_a_in <= 1'b0;
    clear_flag_b_in <= 1'b0;
    m_fa = 0;
    m_fb = 0;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    // Random bounces shorter than the filter
    repeat (4) begin
      drv(1'b1, 1 + ($random(seed) & 1));
      drv(1'b0, 6);
    end
    drv(1'b1, 12);
    mask_rise_in <= 1'b1;
    drv(1'b0, 12);
    mask_fall_in <= 1'b1;
    sleep_req_in <= 1'b1;
    drv(1'b0, 2);
    mode_in <= 3'h2;
    drv(1'b0, 6);
    mode_in <= 3'h0;
    clr;
    drv(1'b0, 2);
    mode_in <= 3'h2;
    drv(1'b1, 12);
    drv(1'b0, 12);
    mode_in <= 3'h4;
    wake_pin_enable_bit_in <= 1'b0;
    drv(1'b1, 12);
    drv(1'b0, 12);
    mode_in <= 3'h1;
    drv(1'b1, 12);
    wake_pin_enable_bit_in <= 1'b1;
    mask_fall_in <= 1'b0;
    drv(1'b0, 12);
    undervoltage_off_in <= 1'b1;
    clr;
    drv(1'b1, 12);
    drv(1'b0, 12);
    undervoltage_off_in <= 1'b0;
    mode_in <= 3'h5;
    drv(1'b1, 12);
    summarize;
  end
  // Watchdog, far beyond the fewer than two hundred cycles expected
  initial begin
    #20000;
    n_mismatch++;
    summarize;
  end
endmodule // tb
